// file: hw/dap_pkg.sv
// constants and types for the decimal adjust / decrement / complement unit
package dap_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_PSW = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_REGS_LO = 8'h10;
  localparam logic [7:0] OFS_REGS_HI = 8'h14;
  localparam logic [7:0] OFS_LATCH = 8'h18;
  localparam logic [7:0] OFS_PINS = 8'h1C;
  localparam logic [7:0] OFS_RAM_LO = 8'h20;
  localparam logic [7:0] OFS_RAM_HI = 8'h24;
  // command field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_MODE_LSB = 2;
  localparam int CMD_IDX_LSB = 4;
  localparam int CMD_AMT_LSB = 8;
  localparam int CMD_ADDR_LSB = 16;
  // program status byte and status register bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_N = 5;
  localparam int PSW_OV = 2;
  localparam int PSW_Z = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CNT_LSB = 8;
  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  // execution states per form
  localparam logic [3:0] ST_DA = 4'h1;
  localparam logic [3:0] ST_DEC_ACC = 4'h1;
  localparam logic [3:0] ST_DEC_REG = 4'h1;
  localparam logic [3:0] ST_DEC_DIR = 4'h2;
  localparam logic [3:0] ST_DEC_IND = 4'h3;
  localparam logic [3:0] ST_PORT_EXTRA = 4'h2;
  localparam logic [3:0] ST_WIDE_B = 4'h1;
  localparam logic [3:0] ST_WIDE_W = 4'h1;
  localparam logic [3:0] ST_WIDE_D = 4'h4;
  localparam logic [3:0] ST_CPL_CY = 4'h1;
  localparam logic [3:0] ST_CPL_BIT = 4'h2;
  typedef enum logic [1:0] {
    DAP_IDLE = 2'b01,
    DAP_RUN = 2'b10
  } dap_state_t;
  typedef enum logic [1:0] {
    OP_DA = 2'h0,
    OP_DEC = 2'h1,
    OP_DEC_WIDE = 2'h2,
    OP_CPL = 2'h3
  } dap_op_t;
  // byte decrement source modes
  localparam logic [1:0] MODE_ACC = 2'h0;
  localparam logic [1:0] MODE_REG = 2'h1;
  localparam logic [1:0] MODE_DIR = 2'h2;
  localparam logic [1:0] MODE_IND = 2'h3;
  // wide decrement widths
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_WORD = 2'h1;
  localparam logic [1:0] WID_DWORD = 2'h2;
endpackage

// file: hw/dap_alu_if.sv
// operand and result wires between the core and its two arithmetic units
`timescale 1ns/1ps
`default_nettype none
interface dap_alu_if;
  logic [7:0] da_acc;
  logic da_cy;
  logic da_ac;
  logic [7:0] da_res;
  logic da_cy_out;
  logic [31:0] dec_val;
  logic [1:0] dec_amt;
  logic [1:0] dec_wid;
  logic [31:0] dec_res;
  logic dec_n;
  logic dec_z;
  modport core (output da_acc, da_cy, da_ac, dec_val, dec_amt, dec_wid,
                input da_res, da_cy_out, dec_res, dec_n, dec_z);
  modport bcd (input da_acc, da_cy, da_ac, output da_res, da_cy_out);
  modport dec (input dec_val, dec_amt, dec_wid,
               output dec_res, dec_n, dec_z);
endinterface
`default_nettype wire

// file: hw/dap_bcd_adj.sv
// packed-bcd correction of the accumulator after an addition
`timescale 1ns/1ps
`default_nettype none
module dap_bcd_adj (
  dap_alu_if.bcd alu
);
  logic low_fix;
  logic high_fix;
  logic [8:0] step1;
  logic [8:0] step2;
  // both digit fixes in one combinational pass, so one cycle suffices
  always_comb begin
    low_fix = (alu.da_acc[3:0] > 4'h9) || alu.da_ac;
    step1 = {1'b0, alu.da_acc} + (low_fix ? 9'h006 : 9'h000);
    high_fix = alu.da_cy || step1[8] || (step1[7:4] > 4'h9);
    step2 = {1'b0, step1[7:0]} + (high_fix ? 9'h060 : 9'h000);
  end
  // net correction is 00, 06, 60 or 66; carry only ever gets set
  assign alu.da_res = step2[7:0];
  assign alu.da_cy_out = step1[8] | step2[8];
endmodule
`default_nettype wire

// file: hw/dap_dec_unit.sv
// subtract 1, 2 or 4 modulo the operand width, with sign and zero
`timescale 1ns/1ps
`default_nettype none
module dap_dec_unit (
  dap_alu_if.dec alu
);
  logic [31:0] amount;
  logic [31:0] diff;
  logic [31:0] masked;
  always_comb begin
    case (alu.dec_amt)
      2'h1: amount = 32'h0000_0002;
      2'h2: amount = 32'h0000_0004;
      default: amount = 32'h0000_0001;
    endcase
    diff = alu.dec_val - amount;
    // wrap by width: the bits above the operand are simply dropped
    case (alu.dec_wid)
      dap_pkg::WID_WORD: masked = {16'h0000, diff[15:0]};
      dap_pkg::WID_DWORD: masked = diff;
      default: masked = {24'h00_0000, diff[7:0]};
    endcase
  end
  assign alu.dec_res = masked;
  assign alu.dec_z = (masked == 32'h0000_0000);
  assign alu.dec_n = (alu.dec_wid == dap_pkg::WID_WORD) ? masked[15] :
                     (alu.dec_wid == dap_pkg::WID_DWORD) ? masked[31] :
                     masked[7];
endmodule
`default_nettype wire

// file: hw/dap_core.sv
// decimal adjust, decrement and bit complement unit behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module dap_core (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [31:0] port_pins_in,
  output logic [31:0] port_latch_out,
  output logic busy_out
);
  typedef struct packed {
    dap_pkg::dap_state_t st;
    logic [3:0] cnt, last_cnt;
    logic [31:0] cmd;
    logic [7:0] acc, program_status_byte;
    logic [7:0][7:0] regs;
    logic [3:0][7:0] latch;
    logic [7:0][7:0] ram;
    logic wr_pend;
    logic [7:0] waddr;
    logic [31:0] rdata;
  } dap_core_state_t;
  dap_core_state_t q, n;
  dap_alu_if alu ();
  logic [1:0] op, mode;
  logic [2:0] idx, ind_ptr;
  logic [7:0] addr, byte_src;
  logic [31:0] wide_src;
  logic dir_port, bit_port, ap_valid, commit, go;
  // only the full word matters; size is accepted but not checked
  logic unused_size;
  assign unused_size = ^{hsize_in, haddr_in[31:8], haddr_in[1:0]};
  dap_bcd_adj u_bcd (.alu(alu.bcd));
  dap_dec_unit u_dec (.alu(alu.dec));
  // command decode, held steady because writes are refused while busy
  assign op = q.cmd[dap_pkg::CMD_OP_LSB +: 2];
  assign mode = q.cmd[dap_pkg::CMD_MODE_LSB +: 2];
  assign idx = q.cmd[dap_pkg::CMD_IDX_LSB +: 3];
  assign addr = q.cmd[dap_pkg::CMD_ADDR_LSB +: 8];
  assign dir_port = (addr[7:6] == 2'b10) && (addr[3:0] == 4'h0);
  assign bit_port = (addr[7:6] == 2'b10) && !addr[3];
  assign ind_ptr = q.regs[{2'b00, idx[0]}][2:0];
  assign ap_valid = hsel_in && htrans_in[1] && hready_in;
  assign commit = (q.st == dap_pkg::DAP_RUN) && (q.cnt == 4'h1);
  assign go = q.wr_pend && (q.st == dap_pkg::DAP_IDLE) &&
              (q.waddr == dap_pkg::OFS_CMD);
  // operand fetch for the byte form; ports come from the latch
  always_comb begin
    case (mode)
      dap_pkg::MODE_REG: byte_src = q.regs[idx];
      dap_pkg::MODE_DIR: byte_src = dir_port ? q.latch[addr[5:4]] :
                                    q.ram[addr[2:0]];
      dap_pkg::MODE_IND: byte_src = q.ram[ind_ptr];
      default: byte_src = q.acc;
    endcase
  end
  // operand fetch for the wide form: byte, word pair or register quad
  always_comb begin
    case (mode)
      dap_pkg::WID_WORD:
        wide_src = {16'h0000, q.regs[{idx[2:1], 1'b0}],
                    q.regs[{idx[2:1], 1'b1}]};
      dap_pkg::WID_DWORD:
        wide_src = {q.regs[{idx[2], 2'b00}], q.regs[{idx[2], 2'b01}],
                    q.regs[{idx[2], 2'b10}], q.regs[{idx[2], 2'b11}]};
      default: wide_src = {24'h00_0000, q.regs[idx]};
    endcase
  end
  // feed the arithmetic units
  assign alu.da_acc = q.acc;
  assign alu.da_cy = q.program_status_byte[dap_pkg::PSW_CY];
  assign alu.da_ac = q.program_status_byte[dap_pkg::PSW_AC];
  assign alu.dec_val = (op == dap_pkg::OP_DEC_WIDE) ? wide_src :
                       {24'h00_0000, byte_src};
  assign alu.dec_amt = (op == dap_pkg::OP_DEC_WIDE) ?
                       q.cmd[dap_pkg::CMD_AMT_LSB +: 2] : 2'h0;
  assign alu.dec_wid = (op == dap_pkg::OP_DEC_WIDE) ? mode :
                       dap_pkg::WID_BYTE;
  // execution states for a command word, port targets cost two more
  function automatic logic [3:0] states_for(input logic [31:0] c);
    logic [1:0] f_op, f_mode;
    logic [7:0] f_addr;
    logic [3:0] s;
    f_op = c[dap_pkg::CMD_OP_LSB +: 2];
    f_mode = c[dap_pkg::CMD_MODE_LSB +: 2];
    f_addr = c[dap_pkg::CMD_ADDR_LSB +: 8];
    case (f_op)
      dap_pkg::OP_DA: s = dap_pkg::ST_DA;
      dap_pkg::OP_DEC: begin
        case (f_mode)
          dap_pkg::MODE_REG: s = dap_pkg::ST_DEC_REG;
          dap_pkg::MODE_DIR: begin
            s = dap_pkg::ST_DEC_DIR;
            if (f_addr[7:6] == 2'b10 && f_addr[3:0] == 4'h0) begin
              s = s + dap_pkg::ST_PORT_EXTRA;
            end
          end
          dap_pkg::MODE_IND: s = dap_pkg::ST_DEC_IND;
          default: s = dap_pkg::ST_DEC_ACC;
        endcase
      end
      dap_pkg::OP_DEC_WIDE: begin
        case (f_mode)
          dap_pkg::WID_WORD: s = dap_pkg::ST_WIDE_W;
          dap_pkg::WID_DWORD: s = dap_pkg::ST_WIDE_D;
          default: s = dap_pkg::ST_WIDE_B;
        endcase
      end
      default: begin
        s = (f_mode == 2'h0) ? dap_pkg::ST_CPL_CY : dap_pkg::ST_CPL_BIT;
        if (f_mode != 2'h0 && f_addr[7:6] == 2'b10 && !f_addr[3]) begin
          s = s + dap_pkg::ST_PORT_EXTRA;
        end
      end
    endcase
    return s;
  endfunction
  // next state: execution, then bus data phase, then bus address phase
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    n = q;
    case (q.st)
      dap_pkg::DAP_RUN: begin
        n.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          n.st = dap_pkg::DAP_IDLE;
          case (op)
            dap_pkg::OP_DA: begin
              n.acc = alu.da_res;
              // carry is or-ed in; overflow is never written here
              n.program_status_byte[dap_pkg::PSW_CY] = q.program_status_byte[dap_pkg::PSW_CY] |
                                       alu.da_cy_out;
            end
            dap_pkg::OP_DEC: begin
              case (mode)
                dap_pkg::MODE_REG: n.regs[idx] = alu.dec_res[7:0];
                dap_pkg::MODE_DIR: begin
                  if (dir_port) begin
                    n.latch[addr[5:4]] = alu.dec_res[7:0];
                  end else begin
                    n.ram[addr[2:0]] = alu.dec_res[7:0];
                  end
                end
                dap_pkg::MODE_IND: n.ram[ind_ptr] = alu.dec_res[7:0];
                default: n.acc = alu.dec_res[7:0];
              endcase
              n.program_status_byte[dap_pkg::PSW_N] = alu.dec_n;
              n.program_status_byte[dap_pkg::PSW_Z] = alu.dec_z;
            end
            dap_pkg::OP_DEC_WIDE: begin
              case (mode)
                dap_pkg::WID_WORD: begin
                  n.regs[{idx[2:1], 1'b0}] = alu.dec_res[15:8];
                  n.regs[{idx[2:1], 1'b1}] = alu.dec_res[7:0];
                end
                dap_pkg::WID_DWORD: begin
                  n.regs[{idx[2], 2'b00}] = alu.dec_res[31:24];
                  n.regs[{idx[2], 2'b01}] = alu.dec_res[23:16];
                  n.regs[{idx[2], 2'b10}] = alu.dec_res[15:8];
                  n.regs[{idx[2], 2'b11}] = alu.dec_res[7:0];
                end
                default: n.regs[idx] = alu.dec_res[7:0];
              endcase
              n.program_status_byte[dap_pkg::PSW_N] = alu.dec_n;
              n.program_status_byte[dap_pkg::PSW_Z] = alu.dec_z;
            end
            default: begin
              // bits above 7f that are not port bits have no storage here
              if (mode == 2'h0) begin
                n.program_status_byte[dap_pkg::PSW_CY] = !q.program_status_byte[dap_pkg::PSW_CY];
              end else if (bit_port) begin
                n.latch[addr[5:4]][addr[2:0]] =
                  !q.latch[addr[5:4]][addr[2:0]];
              end else if (!addr[7]) begin
                n.ram[addr[5:3]][addr[2:0]] =
                  !q.ram[addr[5:3]][addr[2:0]];
              end
            end
          endcase
        end
      end
      default: n.st = dap_pkg::DAP_IDLE;
    endcase
    // write data phase; a busy unit refuses every write
    if (q.wr_pend && q.st == dap_pkg::DAP_IDLE) begin
      case (q.waddr)
        dap_pkg::OFS_CMD: begin
          n.cmd = hwdata_in;
          n.st = dap_pkg::DAP_RUN;
          n.cnt = states_for(hwdata_in);
          n.last_cnt = states_for(hwdata_in);
        end
        dap_pkg::OFS_ACC: n.acc = hwdata_in[7:0];
        dap_pkg::OFS_PSW: n.program_status_byte = hwdata_in[7:0];
        dap_pkg::OFS_REGS_LO: n.regs[3:0] = hwdata_in;
        dap_pkg::OFS_REGS_HI: n.regs[7:4] = hwdata_in;
        dap_pkg::OFS_LATCH: n.latch = hwdata_in;
        dap_pkg::OFS_RAM_LO: n.ram[3:0] = hwdata_in;
        dap_pkg::OFS_RAM_HI: n.ram[7:4] = hwdata_in;
        default: n.cmd = q.cmd;
      endcase
    end
    // address phase: read from the updated copy so back-to-back is fresh
    n.wr_pend = ap_valid && hwrite_in;
    n.waddr = {haddr_in[7:2], 2'b00};
    case (n.waddr)
      dap_pkg::OFS_CMD: rd = n.cmd;
      dap_pkg::OFS_ACC: rd = {24'h00_0000, n.acc};
      dap_pkg::OFS_PSW: rd = {24'h00_0000, n.program_status_byte};
      dap_pkg::OFS_STATUS: begin
        rd[dap_pkg::STAT_BUSY] = (n.st == dap_pkg::DAP_RUN);
        rd[dap_pkg::STAT_CNT_LSB +: 4] = n.last_cnt;
      end
      dap_pkg::OFS_REGS_LO: rd = n.regs[3:0];
      dap_pkg::OFS_REGS_HI: rd = n.regs[7:4];
      dap_pkg::OFS_LATCH: rd = n.latch;
      dap_pkg::OFS_PINS: rd = port_pins_in;
      dap_pkg::OFS_RAM_LO: rd = n.ram[3:0];
      dap_pkg::OFS_RAM_HI: rd = n.ram[7:4];
      default: rd = 32'h0000_0000;
    endcase
    if (ap_valid && !hwrite_in) begin
      n.rdata = rd;
    end
  end
  // the whole state in one register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.st <= dap_pkg::DAP_IDLE;
      q.acc <= dap_pkg::ACC_RST;
      q.program_status_byte <= dap_pkg::PSW_RST;
      q.latch <= {4{dap_pkg::LATCH_RST}};
    end else begin
      q <= n;
    end
  end
  // zero wait states and always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = q.rdata;
  assign port_latch_out = q.latch;
  assign busy_out = (q.st == dap_pkg::DAP_RUN);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [3:0] acc_lo6, acc_hi6;
  assign acc_lo6 = q.acc[3:0] + 4'h6;
  assign acc_hi6 = q.acc[7:4] + 4'h6;
  // busy for a fixed number of states, then idle
  sequence s_run4_done; busy_out [*4] ##1 !busy_out; endsequence
  sequence s_run1_done; busy_out ##1 !busy_out; endsequence
  property p_da_low;
    commit && op == dap_pkg::OP_DA && q.acc[3:0] > 4'h9 |=>
      q.acc[3:0] == $past(acc_lo6);
  endproperty
  a_da_low: assert property (p_da_low)
    else $error("low digit not corrected by six");
  property p_da_high;
    commit && op == dap_pkg::OP_DA && q.program_status_byte[dap_pkg::PSW_CY] &&
      q.acc[3:0] < 4'hA && !q.program_status_byte[dap_pkg::PSW_AC] |=>
      q.acc[7:4] == $past(acc_hi6);
  endproperty
  a_da_high: assert property (p_da_high)
    else $error("high digit not corrected by six");
  property p_da_cy_keep;
    commit && op == dap_pkg::OP_DA && q.program_status_byte[dap_pkg::PSW_CY] |=>
      q.program_status_byte[dap_pkg::PSW_CY];
  endproperty
  a_da_cy_keep: assert property (p_da_cy_keep)
    else $error("decimal adjust cleared carry");
  property p_da_ov;
    commit && op == dap_pkg::OP_DA |=> $stable(q.program_status_byte[dap_pkg::PSW_OV]);
  endproperty
  a_da_ov: assert property (p_da_ov)
    else $error("decimal adjust changed overflow");
  property p_da_one;
    go && hwdata_in[dap_pkg::CMD_OP_LSB +: 2] == dap_pkg::OP_DA |=>
      s_run1_done;
  endproperty
  a_da_one: assert property (p_da_one)
    else $error("decimal adjust not one cycle");
  property p_dec_wrap;
    commit && op == dap_pkg::OP_DEC && mode == dap_pkg::MODE_ACC &&
      q.acc == 8'h00 |=> q.acc == 8'hFF && q.program_status_byte[dap_pkg::PSW_N];
  endproperty
  a_dec_wrap: assert property (p_dec_wrap)
    else $error("zero did not wrap to ff");
  property p_port_time;
    go && hwdata_in[dap_pkg::CMD_OP_LSB +: 2] == dap_pkg::OP_DEC &&
      hwdata_in[dap_pkg::CMD_MODE_LSB +: 2] == dap_pkg::MODE_DIR &&
      hwdata_in[dap_pkg::CMD_ADDR_LSB +: 8] == 8'h90 |=> s_run4_done;
  endproperty
  a_port_time: assert property (p_port_time)
    else $error("port decrement not four states");
  property p_dec_flags;
    commit && (op == dap_pkg::OP_DEC || op == dap_pkg::OP_DEC_WIDE) |=>
      $stable(q.program_status_byte[dap_pkg::PSW_CY]) && $stable(q.program_status_byte[dap_pkg::PSW_AC]) &&
      $stable(q.program_status_byte[dap_pkg::PSW_OV]);
  endproperty
  a_dec_flags: assert property (p_dec_flags)
    else $error("decrement changed carry, aux or overflow");
  property p_cpl_cy;
    commit && op == dap_pkg::OP_CPL && mode == 2'h0 |=>
      q.program_status_byte[dap_pkg::PSW_CY] != $past(q.program_status_byte[dap_pkg::PSW_CY]) &&
      $stable(q.program_status_byte[dap_pkg::PSW_AC]);
  endproperty
  a_cpl_cy: assert property (p_cpl_cy)
    else $error("carry not inverted");
endmodule
`default_nettype wire

// file: verification/dap_core_tb.sv
// self-checking bench for the decimal adjust / decrement / complement unit
`timescale 1ns/1ps
`default_nettype none
module decimal_adjust_decrement_unit_tb_top;
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic hsel_in = 1'h0;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic hready_in;
  logic hreadyout_out;
  logic hresp_out;
  logic [31:0] hrdata_out;
  logic [31:0] port_pins_in = 32'h1234_5678;
  logic [31:0] port_latch_out;
  logic busy_out;
  int miscompares = 0;
  int n_checks = 0;

  // free-running 100 MHz clock
  always #5 clk_in = ~clk_in;
  // single slave: its ready is the bus ready
  assign hready_in = hreadyout_out;

  dap_core u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .port_pins_in(port_pins_in),
    .port_latch_out(port_latch_out), .busy_out(busy_out));

  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one single-word transfer; waits on hready in both phases, bounded
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    hsel_in <= 1'h1;
    haddr_in <= {24'h00_0000, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    @(posedge clk_in);
    while (hready_in !== 1'h1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hready_in !== 1'h1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    rd = hrdata_out;
    chk({31'h0, hresp_out}, 32'h0000_0000);
    if (n >= 50) miscompares++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'h1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'h0, a, 32'h0000_0000, x);
    chk(x, exp);
  endtask

  function automatic logic [31:0] mk(input logic [1:0] op,
      input logic [1:0] md, input logic [2:0] idx, input logic [1:0] amt,
      input logic [7:0] ad);
    return {8'h00, ad, 6'h00, amt, 1'h0, idx, md, op};
  endfunction

  // polls status until idle, then checks the state count of the command
  task automatic wait_done(input logic [3:0] st);
    logic [31:0] x;
    int i;
    x = 32'h0000_0001;
    for (i = 0; i < 20 && x[0] !== 1'h0; i++) xfer(1'h0, 8'h0C, 0, x);
    chk(x & 32'h0000_0F01, {20'h0_0000, st, 8'h00});
    chk({31'h0, busy_out}, 32'h0000_0000);
  endtask

  task automatic run(input logic [31:0] cmd, input logic [3:0] st);
    wr(dap_pkg::OFS_CMD, cmd);
    #1;
    chk({31'h0, busy_out}, 32'h0000_0001);
    wait_done(st);
  endtask

  // guard against a hung handshake or poll
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  logic [7:0] da_a [7] = '{8'hBE, 8'hBE, 8'h99, 8'h12, 8'h45, 8'hFA, 8'h9A};
  logic [7:0] da_p [7] = '{8'h00, 8'h24, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00};
  logic [7:0] da_r [7] = '{8'h24, 8'h24, 8'hF9, 8'h18, 8'h45, 8'h60, 8'h00};
  logic [7:0] da_f [7] = '{8'h80, 8'hA4, 8'h80, 8'h40, 8'h00, 8'h80, 8'h80};

  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'h1;
    // values after reset, unmapped place, read-only pins
    chk(port_latch_out, 32'hFFFF_FFFF);
    rd_chk(dap_pkg::OFS_ACC, 32'h0000_0000);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_0000);
    rd_chk(dap_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk(dap_pkg::OFS_LATCH, 32'hFFFF_FFFF);
    wr(8'h28, 32'hDEAD_BEEF);
    rd_chk(8'h28, 32'h0000_0000);
    wr(dap_pkg::OFS_PINS, 32'h0000_0000);
    rd_chk(dap_pkg::OFS_PINS, 32'h1234_5678);
    // decimal adjust: every correction constant, carry kept, flags kept
    for (int i = 0; i < 7; i++) begin
      wr(dap_pkg::OFS_ACC, {24'h00_0000, da_a[i]});
      wr(dap_pkg::OFS_PSW, {24'h00_0000, da_p[i]});
      run(mk(dap_pkg::OP_DA, 2'h0, 3'h0, 2'h0, 8'h00), dap_pkg::ST_DA);
      rd_chk(dap_pkg::OFS_ACC, {24'h00_0000, da_r[i]});
      rd_chk(dap_pkg::OFS_PSW, {24'h00_0000, da_f[i]});
    end
    // byte decrement of the accumulator, wrapping from zero
    wr(dap_pkg::OFS_ACC, 32'h0000_0000);
    wr(dap_pkg::OFS_PSW, 32'h0000_00C4);
    run(mk(dap_pkg::OP_DEC, dap_pkg::MODE_ACC, 3'h0, 2'h0, 8'h00),
        dap_pkg::ST_DEC_ACC);
    rd_chk(dap_pkg::OFS_ACC, 32'h0000_00FF);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00E4);
    // working register down to zero
    wr(dap_pkg::OFS_REGS_LO, 32'h0403_0101);
    run(mk(dap_pkg::OP_DEC, dap_pkg::MODE_REG, 3'h1, 2'h0, 8'h00),
        dap_pkg::ST_DEC_REG);
    rd_chk(dap_pkg::OFS_REGS_LO, 32'h0403_0001);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00C6);
    // direct byte in on-chip memory
    wr(dap_pkg::OFS_RAM_HI, 32'h0000_7F00);
    run(mk(dap_pkg::OP_DEC, dap_pkg::MODE_DIR, 3'h0, 2'h0, 8'h05),
        dap_pkg::ST_DEC_DIR);
    rd_chk(dap_pkg::OFS_RAM_HI, 32'h0000_7E00);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00C4);
    // port one: latch is the source although pins differ
    run(mk(dap_pkg::OP_DEC, dap_pkg::MODE_DIR, 3'h0, 2'h0, 8'h90),
        dap_pkg::ST_DEC_DIR + dap_pkg::ST_PORT_EXTRA);
    rd_chk(dap_pkg::OFS_LATCH, 32'hFFFF_FEFF);
    chk(port_latch_out, 32'hFFFF_FEFF);
    // indirect through register zero, which holds one
    wr(dap_pkg::OFS_RAM_LO, 32'h0000_8000);
    run(mk(dap_pkg::OP_DEC, dap_pkg::MODE_IND, 3'h0, 2'h0, 8'h00),
        dap_pkg::ST_DEC_IND);
    rd_chk(dap_pkg::OFS_RAM_LO, 32'h0000_7F00);
    // wide forms: word by two, byte by one, dword by one then four
    wr(dap_pkg::OFS_REGS_LO, 32'h0000_0000);
    run(mk(dap_pkg::OP_DEC_WIDE, dap_pkg::WID_WORD, 3'h0, 2'h1, 8'h00),
        dap_pkg::ST_WIDE_W);
    rd_chk(dap_pkg::OFS_REGS_LO, 32'h0000_FEFF);
    run(mk(dap_pkg::OP_DEC_WIDE, dap_pkg::WID_BYTE, 3'h3, 2'h0, 8'h00),
        dap_pkg::ST_WIDE_B);
    rd_chk(dap_pkg::OFS_REGS_LO, 32'hFF00_FEFF);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00E4);
    wr(dap_pkg::OFS_REGS_HI, 32'h0100_0000);
    run(mk(dap_pkg::OP_DEC_WIDE, dap_pkg::WID_DWORD, 3'h4, 2'h3, 8'h00),
        dap_pkg::ST_WIDE_D);
    rd_chk(dap_pkg::OFS_REGS_HI, 32'h0000_0000);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00C6);
    // a write landing while busy is dropped
    wr(dap_pkg::OFS_CMD, mk(dap_pkg::OP_DEC_WIDE, dap_pkg::WID_DWORD, 3'h4,
       2'h2, 8'h00));
    wr(dap_pkg::OFS_ACC, 32'h0000_0055);
    wait_done(dap_pkg::ST_WIDE_D);
    rd_chk(dap_pkg::OFS_ACC, 32'h0000_00FF);
    rd_chk(dap_pkg::OFS_REGS_HI, 32'hFCFF_FFFF);
    // complement carry twice, other flags held
    wr(dap_pkg::OFS_PSW, 32'h0000_0064);
    run(mk(dap_pkg::OP_CPL, 2'h0, 3'h0, 2'h0, 8'h00), dap_pkg::ST_CPL_CY);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_00E4);
    run(mk(dap_pkg::OP_CPL, 2'h0, 3'h0, 2'h0, 8'h00), dap_pkg::ST_CPL_CY);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_0064);
    // memory bit, port bit and an address with no bit behind it
    run(mk(dap_pkg::OP_CPL, 2'h1, 3'h0, 2'h0, 8'h0B), dap_pkg::ST_CPL_BIT);
    rd_chk(dap_pkg::OFS_RAM_LO, 32'h0000_7700);
    run(mk(dap_pkg::OP_CPL, 2'h1, 3'h0, 2'h0, 8'hA5),
        dap_pkg::ST_CPL_BIT + dap_pkg::ST_PORT_EXTRA);
    chk(port_latch_out, 32'hFFDF_FEFF);
    run(mk(dap_pkg::OP_CPL, 2'h1, 3'h0, 2'h0, 8'hC0), dap_pkg::ST_CPL_BIT);
    rd_chk(dap_pkg::OFS_LATCH, 32'hFFDF_FEFF);
    rd_chk(dap_pkg::OFS_PSW, 32'h0000_0064);
    end_sim();
  end
endmodule
`default_nettype wire
